// *** hdl/tirio_consts.svh ***
// Purpose: shared constants of the trigger input and relay block
// Assumes: included by its bare name from design and bench files
// Notes:   offsets are byte addresses on the register bus
`ifndef TIRIO_CONSTS_SVH
`define TIRIO_CONSTS_SVH

// ============================================================
// register map
`define TIRIO_ADDR_MAP     8'h00
`define TIRIO_ADDR_TYPE    8'h04
`define TIRIO_ADDR_OUT     8'h08
`define TIRIO_ADDR_STATUS  8'h0c

// ============================================================
// reset values
`define TIRIO_MAP_RST      8'he4
`define TIRIO_TYPE_RST     8'h00
`define TIRIO_OUT_RST      4'h0

// ============================================================
// field positions
`define TIRIO_OUT_TTL_LSB    0
`define TIRIO_OUT_RELAY_LSB  2
`define TIRIO_ST_VALVE       4
`define TIRIO_ST_PUMP        5
`define TIRIO_ST_MARK        6

// ============================================================
// timing
`define TIRIO_CLK_NS       10
`define TIRIO_MS_NS        1000000
`define TIRIO_QUAL_MS      10
`define TIRIO_MARK_MS      500
`define TIRIO_MARK_PCT     8'h0a

`endif

// *** hdl/tirio_pkg.sv ***
// Purpose: types shared by the trigger input and relay block
// Assumes: constants come from tirio_consts.svh
// Notes:   nothing here holds state
`default_nettype none

package tirio_pkg;

	// ========================================================
	// interpretation of one trigger input
	typedef enum logic [1:0] {
		TIRIO_LEVEL_LOW  = 2'b00,
		TIRIO_LEVEL_HIGH = 2'b01,
		TIRIO_STROBE_LOW = 2'b10,
		TIRIO_STROBE_HIGH = 2'b11
	} tirio_type_t;

	// instrument functions, also the slot index in the map register
	typedef enum logic [1:0] {
		TIRIO_FN_VALVE = 2'b00,
		TIRIO_FN_NULL  = 2'b01,
		TIRIO_FN_FLOW  = 2'b10,
		TIRIO_FN_TICK  = 2'b11
	} tirio_fn_t;

	// input level seen as active for the chosen interpretation
	function automatic logic tirio_active(input logic lvl,
		input logic [1:0] typ);
		tirio_active = typ[0] ? lvl : ~lvl;
	endfunction

endpackage

`default_nettype wire

// *** hdl/tirio_top.sv ***
// Purpose: trigger input conditioning, function routing, logic and
//          relay outputs behind an APB register slave
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   trigger pins are asynchronous and are synchronised here
//
// The register offsets and register access over APB are this design's own decisions.
`include "tirio_consts.svh"
`default_nettype none

module tirio_top #(
	parameter int CYC_PER_MS = `TIRIO_MS_NS / `TIRIO_CLK_NS,
	parameter int QUAL_MS    = `TIRIO_QUAL_MS,
	parameter int MARK_MS    = `TIRIO_MARK_MS
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [3:0]  trigIn,
	output var  logic [1:0]  ttlOut,
	output var  logic [1:0]  relayClose,
	output var  logic        valveInject,
	output var  logic        nullCmd,
	output var  logic        pumpOn,
	output var  logic        suppressorOn,
	output var  logic        markActive,
	output var  logic [7:0]  markPercent
);

	// ========================================================
	// elaboration checks
	localparam int DIV_W  = $clog2(CYC_PER_MS);
	localparam int QUAL_W = $clog2(QUAL_MS + 1);
	localparam int MARK_W = $clog2(MARK_MS + 1);

	// the divider needs two cycles a millisecond at least
	if (CYC_PER_MS < 2) begin : gBadDiv
		$error("tirio_top: CYC_PER_MS below 2");
	end
	// qualification must land above 4 ms and below 50 ms of width
	if (QUAL_MS < 6 || QUAL_MS > 48) begin : gBadQual
		$error("tirio_top: QUAL_MS outside 6 to 48");
	end
	// a marker of zero length could never be seen
	if (MARK_MS < 1) begin : gBadMark
		$error("tirio_top: MARK_MS below 1");
	end

	// ========================================================
	// input synchroniser
	logic [3:0] syncA;
	logic [3:0] syncB;

	// first stage feeds only the second one
	// both rest at the idle high level, so reset makes no false edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			syncA <= 4'hf;
			syncB <= 4'hf;
		end else begin
			syncA <= trigIn;
			syncB <= syncA;
		end
	end

	// ========================================================
	// millisecond tick divider
	logic [DIV_W-1:0] divCnt;
	logic [DIV_W-1:0] next_divCnt;
	logic             msTick;
	logic             next_msTick;

	// one-cycle enable once per millisecond
	always_comb begin
		next_msTick = 1'b0;
		next_divCnt = divCnt + 1'b1;
		if (divCnt == DIV_W'(CYC_PER_MS - 1)) begin
			next_divCnt = '0;
			next_msTick = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			divCnt <= '0;
			msTick <= 1'b0;
		end else begin
			divCnt <= next_divCnt;
			msTick <= next_msTick;
		end
	end

	// ========================================================
	// host registers
	logic [7:0] mapSel;
	logic [7:0] next_mapSel;
	logic [7:0] typeSel;
	logic [7:0] next_typeSel;
	logic [3:0] outCtl;
	logic [3:0] next_outCtl;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        addrHit;
	logic        wrDone;
	logic [31:0] rdMux;

	// true for the four word addresses, low two bits zero
	function automatic logic regMapped(input logic [7:0] a);
		regMapped = (a[1:0] == 2'b00) &&
			(a == `TIRIO_ADDR_MAP || a == `TIRIO_ADDR_TYPE ||
			 a == `TIRIO_ADDR_OUT || a == `TIRIO_ADDR_STATUS);
	endfunction

	// decode the word address and pick the read value
	always_comb begin
		addrHit = regMapped(paddr);
		case (paddr)
			`TIRIO_ADDR_MAP:    rdMux = {24'h0, mapSel};
			`TIRIO_ADDR_TYPE:   rdMux = {24'h0, typeSel};
			`TIRIO_ADDR_OUT:    rdMux = {28'h0, outCtl};
			`TIRIO_ADDR_STATUS: rdMux = {25'h0, markActive, pumpOn,
				valveInject, syncB};
			default:            rdMux = 32'h0;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_comb begin
		next_pready  = psel & penable & ~pready;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		wrDone       = psel & penable & pready & pwrite & addrHit;
		next_mapSel  = mapSel;
		next_typeSel = typeSel;
		next_outCtl  = outCtl;
		if (psel & penable & ~pready) begin
			next_prdata  = pwrite ? 32'h0 : rdMux;
			next_pslverr = ~addrHit;
		end
		if (wrDone) begin
			case (paddr)
				`TIRIO_ADDR_MAP:  next_mapSel  = pwdata[7:0];
				`TIRIO_ADDR_TYPE: next_typeSel = pwdata[7:0];
				`TIRIO_ADDR_OUT:  next_outCtl  = pwdata[3:0];
				// the read-only status word ignores writes, no error
				default:          next_outCtl  = outCtl;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
			mapSel  <= `TIRIO_MAP_RST;
			typeSel <= `TIRIO_TYPE_RST;
			outCtl  <= `TIRIO_OUT_RST;
		end else begin
			pready  <= next_pready;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
			mapSel  <= next_mapSel;
			typeSel <= next_typeSel;
			outCtl  <= next_outCtl;
		end
	end

	// ========================================================
	// per-input edge and strobe detection
	logic [3:0]        actNow;
	logic [3:0]        actPrev;
	logic [3:0]        next_actPrev;
	logic [QUAL_W-1:0] width [4];
	logic [QUAL_W-1:0] next_width [4];
	logic [3:0]        onEvt;
	logic [3:0]        offEvt;

	// level types give both edges, strobes only a qualified start;
	// the previous level is judged under the type of the next cycle
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			actNow[i] = tirio_pkg::tirio_active(syncB[i],
				typeSel[2*i +: 2]);
			// a type write must not look like a pin edge
			next_actPrev[i] = tirio_pkg::tirio_active(syncB[i],
				next_typeSel[2*i +: 2]);
			next_width[i] = width[i];
			onEvt[i]  = 1'b0;
			offEvt[i] = 1'b0;
			if (!typeSel[2*i+1]) begin
				onEvt[i]  = actNow[i] & ~actPrev[i];
				offEvt[i] = ~actNow[i] & actPrev[i];
				next_width[i] = '0;
			end else if (!actNow[i]) begin
				next_width[i] = '0;  // inactive edge ignored
			end else if (msTick && width[i] != QUAL_W'(QUAL_MS)) begin
				// width saturates so one long strobe fires once
				next_width[i] = width[i] + 1'b1;
				onEvt[i] = (width[i] == QUAL_W'(QUAL_MS - 1));
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			actPrev <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				width[i] <= '0;
			end
		end else begin
			actPrev <= next_actPrev;
			for (int i = 0; i < 4; i++) begin
				width[i] <= next_width[i];
			end
		end
	end

	// ========================================================
	// function routing
	logic [3:0] fnOn;
	logic [3:0] fnOff;

	// each function listens to the input its map slot names
	always_comb begin
		for (int f = 0; f < 4; f++) begin
			fnOn[f]  = onEvt[mapSel[2*f +: 2]];
			fnOff[f] = offEvt[mapSel[2*f +: 2]];
		end
	end

	// ========================================================
	// instrument function state
	logic              next_valveInject;
	logic              next_nullCmd;
	logic              next_pumpOn;
	logic              next_markActive;
	logic [7:0]        next_markPercent;
	logic [MARK_W-1:0] markLeft;
	logic [MARK_W-1:0] next_markLeft;

	// active start wins over a stop in the same cycle;
	// the first tick may come at once, so the marker lasts
	// between MARK_MS-1 and MARK_MS milliseconds
	always_comb begin
		next_valveInject = valveInject;
		next_pumpOn      = pumpOn;
		next_markActive  = markActive;
		next_markLeft    = markLeft;
		// the valve, null, pump and marker functions are all steered from here
		if (fnOn[tirio_pkg::TIRIO_FN_VALVE]) begin
			next_valveInject = 1'b0;  // load
		end else if (fnOff[tirio_pkg::TIRIO_FN_VALVE]) begin
			next_valveInject = 1'b1;  // inject
		end
		// null command lasts exactly one cycle
		next_nullCmd = fnOn[tirio_pkg::TIRIO_FN_NULL];
		if (fnOn[tirio_pkg::TIRIO_FN_FLOW]) begin
			next_pumpOn = 1'b1;
		end else if (fnOff[tirio_pkg::TIRIO_FN_FLOW]) begin
			next_pumpOn = 1'b0;
		end
		// a new tick restarts the marker window
		if (fnOn[tirio_pkg::TIRIO_FN_TICK]) begin
			next_markActive = 1'b1;
			next_markLeft   = MARK_W'(MARK_MS);
		end else if (markActive && msTick) begin
			next_markLeft = markLeft - 1'b1;
			if (markLeft == MARK_W'(1)) begin
				next_markActive = 1'b0;
			end
		end
		next_markPercent = next_markActive ? `TIRIO_MARK_PCT : 8'h00;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			valveInject  <= 1'b0;
			nullCmd      <= 1'b0;
			pumpOn       <= 1'b0;
			suppressorOn <= 1'b0;
			markActive   <= 1'b0;
			markLeft     <= '0;
			markPercent  <= 8'h00;
		end else begin
			valveInject  <= next_valveInject;
			nullCmd      <= next_nullCmd;
			pumpOn       <= next_pumpOn;
			suppressorOn <= next_pumpOn;  // follows pump
			markActive   <= next_markActive;
			markLeft     <= next_markLeft;
			markPercent  <= next_markPercent;
		end
	end

	// ========================================================
	// logic and relay output drivers
	logic [1:0] next_ttlOut;
	logic [1:0] next_relayClose;

	// a set control bit means active: logic low, relay closed
	always_comb begin
		next_ttlOut     = ~next_outCtl[`TIRIO_OUT_TTL_LSB +: 2];
		next_relayClose = next_outCtl[`TIRIO_OUT_RELAY_LSB +: 2];
	end

	// two of each output, resting high and open
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ttlOut     <= 2'b11;
			relayClose <= 2'b00;
		end else begin
			ttlOut     <= next_ttlOut;
			relayClose <= next_relayClose;
		end
	end

endmodule

`default_nettype wire

// *** sim/tirio_chk_sva.sv ***
// Purpose: port-level checks on tirio_top
// Assumes: bound from the bench top file
// Notes:   one clock domain, so default clocking is used
`include "tirio_consts.svh"
`default_nettype none
module tirio_chk (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  ttlOut,
	input wire logic [1:0]  relayClose,
	input wire logic        nullCmd,
	input wire logic        pumpOn,
	input wire logic        suppressorOn,
	input wire logic        markActive,
	input wire logic [7:0]  markPercent
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// ======================================================
	// register bus and host outputs
	chk_one_wait: assert property (
		psel && penable && !pready |=> pready)
		else $error("bus answer missing after wait state");
	chk_err_pair: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	chk_relay_wr: assert property (
		psel && penable && pready && pwrite &&
		paddr == `TIRIO_ADDR_OUT |=> relayClose == $past(pwdata[3:2]))
		else $error("relay state differs from write");
	chk_ttl_wr: assert property (
		psel && penable && pready && pwrite &&
		paddr == `TIRIO_ADDR_OUT |=> ttlOut == ~$past(pwdata[1:0]))
		else $error("logic output differs from write");
	chk_ttl_rst: assert property ($past(reset) |-> ttlOut == 2'b11)
		else $error("logic outputs not idle high");
	chk_relay_rst: assert property (
		$past(reset) |-> relayClose == 2'b00)
		else $error("relays not open after reset");
	// ======================================================
	// function outputs
	chk_supp_same: assert property (suppressorOn == pumpOn)
		else $error("suppressor differs from pump");
	chk_mark_pct: assert property (
		markPercent == (markActive ? `TIRIO_MARK_PCT : 8'h00))
		else $error("marker level wrong");
	chk_null_once: assert property (nullCmd |=> !nullCmd)
		else $error("zero command longer than one cycle");
	chk_mark_hold: assert property (
		$rose(markActive) |-> markActive [*8])
		else $error("marker dropped early");
	cover property (nullCmd);
	cover property ($rose(markActive));
	cover property (pslverr);
endmodule
`default_nettype wire

// *** sim/tirio_ctrl_model.sv ***
// Purpose: controlling instrument that drives the trigger lines
// Assumes: called from the bench right after a clock edge
// Notes:   lines always driven, idle high
`default_nettype none
module tirio_ctrl_model (
	input  wire logic       core_clk,
	output var  logic [3:0] trigIn
);
	timeunit 1ns;
	timeprecision 1ns;
	initial trigIn = 4'hf;
	// ======================================================
	// one line set, or one pulse of n clock cycles
	task automatic drive(input int i, input logic v);
		trigIn[i] <= v;
	endtask
	// callers keep widths outside the undefined band
	task automatic pulse(input int i, input logic act, input int n);
		drive(i, act);
		repeat (n) @(posedge core_clk);
		drive(i, ~act);
		// let an edge pass so a following drive is a new time step
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// *** sim/tirio_tb.sv ***
// Purpose: self-checking bench for tirio_top
// Assumes: 1 ms shortened to 10 cycles, marker to 5 ms
// Notes:   level responses checked 6 cycles after a pin change
`include "tirio_consts.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
	logic        rerr, nullCmd, pumpOn, suppressorOn, valveInject, markActive;
	logic [7:0]  paddr, markPercent;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  trigIn;
	logic [1:0]  ttlOut, relayClose;
	int          bad_count, samples_checked, cyc, nulls;
	// rows: OUT value, expected ttlOut, expected relayClose
	logic [7:0]  rows [4] = '{8'h59, 8'ha6, 8'hf3, 8'h0c};
	// ======================================================
	// clock, parts, watchdog
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	tirio_top #(.CYC_PER_MS(10), .QUAL_MS(10), .MARK_MS(5)) u_dut (.core_clk,
		.reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .trigIn, .ttlOut, .relayClose, .valveInject, .nullCmd,
		.pumpOn, .suppressorOn, .markActive, .markPercent);
	tirio_ctrl_model u_ctl (.core_clk, .trigIn);
	// zero commands are pulses, so count them as they pass
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (nullCmd === 1'b1)
			nulls <= nulls + 1;
		if (cyc == 5000) begin
			bad_count++;
			results();
		end
	end
	// ======================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pin(input int i, input logic v, input string nm,
		input logic [31:0] exp);
		u_ctl.drive(i, v);
		wt(6);
		if (nm == "valve") chk(nm, valveInject, exp);
		else if (nm == "pump") begin
			chk(nm, pumpOn, exp);
			chk("supp", suppressorOn, exp);
		end
		else chk(nm, nulls, exp);
	endtask
	task results;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ======================================================
	// main sequence
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {4'h9, 40'h0};
		{bad_count, samples_checked, cyc, nulls} = '0;
		wt(4);
		reset <= 1'b0;
		wt(1);
		chk("ttl", ttlOut, 2'b11);
		chk("relay", relayClose, 0);
		apb(0, `TIRIO_ADDR_MAP, 0);
		chk("map", rdat, 32'he4);
		apb(0, `TIRIO_ADDR_TYPE, 0);
		chk("type", rdat, 0);
		apb(0, 8'h10, 0);
		chk("err", rerr, 1);
		foreach (rows[i]) begin
			apb(1, `TIRIO_ADDR_OUT, rows[i][7:4]);
			wt(1);
			chk("ttl", ttlOut, rows[i][3:2]);
			chk("relay", relayClose, rows[i][1:0]);
		end
		pin(0, 0, "valve", 0);
		pin(0, 1, "valve", 1);
		pin(0, 0, "valve", 0);
		pin(2, 0, "pump", 1);
		pin(2, 1, "pump", 0);
		pin(1, 0, "null", 1);
		pin(1, 1, "null", 1);
		u_ctl.drive(3, 0);
		wt(6);
		chk("mark", markPercent, 8'h0a);
		wt(35);
		chk("mark", markPercent, 8'h0a);
		wt(20);
		chk("mark", markPercent, 0);
		u_ctl.drive(3, 1);
		apb(1, `TIRIO_ADDR_TYPE, 32'h1);
		pin(0, 1, "valve", 0);
		pin(0, 0, "valve", 1);
		apb(1, `TIRIO_ADDR_TYPE, 32'h23);
		u_ctl.pulse(0, 1, 40);
		pin(0, 0, "valve", 1);
		// accepted strobes last 500 cycles, 50 ms at this scale
		u_ctl.pulse(0, 1, 500);
		pin(0, 0, "valve", 0);
		u_ctl.pulse(2, 0, 40);
		pin(2, 1, "pump", 0);
		u_ctl.pulse(2, 0, 500);
		pin(2, 1, "pump", 1);
		apb(1, `TIRIO_ADDR_MAP, 32'he5);
		pin(1, 0, "null", 2);
		pin(1, 1, "valve", 1);
		u_ctl.pulse(0, 1, 500);
		pin(0, 0, "valve", 1);
		apb(0, `TIRIO_ADDR_STATUS, 0);
		chk("status", rdat[6:4], 3'b011);
		// mid-run reset with outputs active clears the host state
		apb(1, `TIRIO_ADDR_OUT, 32'hf);
		reset <= 1'b1;
		wt(2);
		reset <= 1'b0;
		wt(1);
		chk("ttl", ttlOut, 2'b11);
		chk("relay", relayClose, 0);
		chk("pump", pumpOn, 0);
		chk("valve", valveInject, 0);
		apb(0, `TIRIO_ADDR_TYPE, 0);
		chk("type", rdat, 0);
		apb(0, `TIRIO_ADDR_MAP, 0);
		chk("map", rdat, 32'he4);
		results();
	end
endmodule
bind tirio_top tirio_chk u_chk (.core_clk, .reset, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .ttlOut, .relayClose, .nullCmd,
	.pumpOn, .suppressorOn, .markActive, .markPercent);
`default_nettype wire
